/* pkg/gdt_pkg.sv */
// constants, register map and carrier types of the gate-drive dead-time block
package gdt_pkg;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DT_STEP_NS = 4;
  localparam int FSW_MIN_HZ = 100_000;
  localparam int FSW_MAX_HZ = 1_600_000;
  // longest period rounds down, shortest rounds up, so fsw stays inside its range
  localparam int PERIOD_MAX_CYC = CLK_HZ / FSW_MIN_HZ;
  localparam int PERIOD_MIN_CYC = (CLK_HZ + FSW_MAX_HZ - 1) / FSW_MAX_HZ;

  // widths
  localparam int REG_AW = 3;
  localparam int REG_DW = 16;
  localparam int CNT_W = 10;
  localparam int DT_W = 4;
  localparam int ELAPSED_W = 7;

  // register offsets
  localparam logic [REG_AW-1:0] REG_PERIOD = 3'h0;
  localparam logic [REG_AW-1:0] REG_DUTY = 3'h1;
  localparam logic [REG_AW-1:0] REG_DEAD_TIME_CONFIG = 3'h2;
  localparam logic [REG_AW-1:0] REG_DRIVER_OPTION = 3'h3;
  localparam logic [REG_AW-1:0] REG_DRIVER_TEST_CONTROL = 3'h4;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h5;
  localparam logic [REG_AW-1:0] REG_COUNT = 3'h6;

  // field positions
  localparam int DT_HIGH_LSB = 0;
  localparam int DT_LOW_LSB = 4;
  localparam int OPT_HIGH_BYP_BIT = 0;
  localparam int OPT_LOW_BYP_BIT = 1;
  localparam int OPT_REDUCED_BIT = 2;
  localparam int TST_DRV_OFF_BIT = 0;
  localparam int TST_HIGH_OFF_BIT = 1;
  localparam int TST_LOW_OFF_BIT = 2;
  localparam int STS_HIGH_BIT = 0;
  localparam int STS_LOW_BIT = 1;
  localparam int STS_PWM_BIT = 2;

  // reset values
  localparam logic [CNT_W-1:0] PERIOD_RST = 10'h3e7;
  localparam logic [CNT_W-1:0] DUTY_RST = 10'h000;
  localparam logic [7:0] DT_CFG_RST = 8'h00;
  localparam logic [2:0] OPT_RST = 3'h0;
  // driver starts off so nothing switches before software is ready
  localparam logic [2:0] TST_RST = 3'h1;

  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [REG_DW-1:0] wdata;
    logic wr;
    logic rd;
  } gdt_req_t;

  typedef struct packed {
    logic on;
    logic [ELAPSED_W-1:0] elapsed;
  } gdt_side_st_t;
endpackage

/* design/gdt_side.sv */
// one gate-drive output with dead-time insertion and interlock
`timescale 1ns/1ps
module gdt_side import gdt_pkg::*; #(
  parameter int SIDE_DT_W = DT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req,
  input wire logic other_on,
  input wire logic bypass,
  input wire logic off,
  input wire logic [SIDE_DT_W-1:0] dt_code,
  output logic drive_q
);
  gdt_side_st_t st_q;
  gdt_side_st_t st_d;
  logic [ELAPSED_W-1:0] target;

  if (((2 ** SIDE_DT_W) - 1) * DT_STEP_NS + CLK_PERIOD_NS >= 2 ** ELAPSED_W) begin : g_chk
    $error("dead-time code too wide for elapsed counter");
  end

  always_comb begin
    target = ELAPSED_W'(dt_code) * ELAPSED_W'(DT_STEP_NS);
    st_d = st_q;
    if (off || !req) begin
      st_d = '0;
    end else if (!st_q.on) begin
      // the elapsed time only runs once the other gate is seen low
      if (other_on) begin
        st_d.elapsed = '0;
      end else if (bypass || st_q.elapsed >= target) begin
        st_d.on = 1'b1;
      end else begin
        st_d.elapsed = st_q.elapsed + ELAPSED_W'(CLK_PERIOD_NS);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign drive_q = st_q.on;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  rise_after_other_a: assert property ($rose(drive_q) |-> !$past(other_on) && !other_on)
    else $error("gate rose while complementary gate was high");
  dead_time_len_a: assert property ($rose(drive_q) && !$past(bypass) |-> $past(st_q.elapsed) >= $past(target))
    else $error("gate rose before programmed dead time elapsed");
  bypass_rise_a: assert property (bypass && req && !off && !other_on && !drive_q |=> drive_q)
    else $error("bypassed side did not rise on the next edge");
endmodule // gdt_side

/* design/gdt_top.sv */
// gate-drive control: period timer, register port, two dead-time sides
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module gdt_top import gdt_pkg::*; #(
  parameter int TOP_CNT_W = CNT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire gdt_req_t bus,
  output logic [REG_DW-1:0] reg_rdata,
  output logic high_gate_drive,
  output logic low_gate_drive,
  output logic high_drive_reduced
);
  typedef struct packed {
    logic [TOP_CNT_W-1:0] period;
    logic [TOP_CNT_W-1:0] duty;
    logic [7:0] dt_cfg;
    logic [2:0] opt;
    logic [2:0] test;
    logic [TOP_CNT_W-1:0] count;
    logic [REG_DW-1:0] rdata;
  } gdt_top_st_t;

  localparam logic [TOP_CNT_W-1:0] PER_LO = TOP_CNT_W'(PERIOD_MIN_CYC - 1);
  localparam logic [TOP_CNT_W-1:0] PER_HI = TOP_CNT_W'(PERIOD_MAX_CYC - 1);

  if (2 ** TOP_CNT_W < PERIOD_MAX_CYC || TOP_CNT_W > REG_DW) begin : g_chk
    $error("period counter width cannot hold the longest period");
  end

  gdt_top_st_t st_q;
  gdt_top_st_t st_d;
  logic pwm_on;
  logic drv_off;
  logic wr_val_lo;
  logic wr_val_hi;
  logic [TOP_CNT_W-1:0] wr_val;

  always_comb begin
    st_d = st_q;
    wr_val = bus.wdata[TOP_CNT_W-1:0];
    wr_val_lo = wr_val < PER_LO;
    wr_val_hi = wr_val > PER_HI;
    // counter wraps on >= so a shorter period written mid-cycle cannot run away
    if (st_q.count >= st_q.period) begin
      st_d.count = '0;
    end else begin
      st_d.count = st_q.count + 1'b1;
    end
    if (bus.wr) begin
      unique case (bus.addr)
        REG_PERIOD: begin
          // out-of-range periods are clamped instead of refused
          if (wr_val_lo) begin
            st_d.period = PER_LO;
          end else if (wr_val_hi) begin
            st_d.period = PER_HI;
          end else begin
            st_d.period = wr_val;
          end
        end
        REG_DUTY: begin
          st_d.duty = wr_val;
        end
        REG_DEAD_TIME_CONFIG: begin
          st_d.dt_cfg = bus.wdata[7:0];
        end
        REG_DRIVER_OPTION: begin
          st_d.opt = bus.wdata[2:0];
        end
        REG_DRIVER_TEST_CONTROL: begin
          st_d.test = bus.wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    st_d.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        REG_PERIOD: begin
          st_d.rdata = REG_DW'(st_q.period);
        end
        REG_DUTY: begin
          st_d.rdata = REG_DW'(st_q.duty);
        end
        REG_DEAD_TIME_CONFIG: begin
          st_d.rdata = REG_DW'(st_q.dt_cfg);
        end
        REG_DRIVER_OPTION: begin
          st_d.rdata = REG_DW'(st_q.opt);
        end
        REG_DRIVER_TEST_CONTROL: begin
          st_d.rdata = REG_DW'(st_q.test);
        end
        REG_STATUS: begin
          st_d.rdata[STS_HIGH_BIT] = high_gate_drive;
          st_d.rdata[STS_LOW_BIT] = low_gate_drive;
          st_d.rdata[STS_PWM_BIT] = pwm_on;
        end
        REG_COUNT: begin
          st_d.rdata = REG_DW'(st_q.count);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q.period <= PERIOD_RST;
      st_q.duty <= DUTY_RST;
      st_q.dt_cfg <= DT_CFG_RST;
      st_q.opt <= OPT_RST;
      st_q.test <= TST_RST;
      st_q.count <= '0;
      st_q.rdata <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pwm_on = st_q.count < st_q.duty;
  assign drv_off = st_q.test[TST_DRV_OFF_BIT];

  // each side sees the other's registered gate, so an overlap is impossible
  gdt_side #(.SIDE_DT_W(DT_W)) u_high (
    .mclk(mclk),
    .rst(rst),
    .req(pwm_on),
    .other_on(low_gate_drive),
    .bypass(st_q.opt[OPT_HIGH_BYP_BIT]),
    .off(drv_off || st_q.test[TST_HIGH_OFF_BIT]),
    .dt_code(st_q.dt_cfg[DT_HIGH_LSB +: DT_W]),
    .drive_q(high_gate_drive)
  );

  gdt_side #(.SIDE_DT_W(DT_W)) u_low (
    .mclk(mclk),
    .rst(rst),
    .req(!pwm_on),
    .other_on(high_gate_drive),
    .bypass(st_q.opt[OPT_LOW_BYP_BIT]),
    .off(drv_off || st_q.test[TST_LOW_OFF_BIT]),
    .dt_code(st_q.dt_cfg[DT_LOW_LSB +: DT_W]),
    .drive_q(low_gate_drive)
  );

  assign high_drive_reduced = st_q.opt[OPT_REDUCED_BIT];
  assign reg_rdata = st_q.rdata;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence high_run_s;
    (!drv_off && !st_q.test[TST_HIGH_OFF_BIT] && pwm_on) [*8];
  endsequence

  sequence low_run_s;
    (st_q.test[TST_HIGH_OFF_BIT] && !drv_off && !st_q.test[TST_LOW_OFF_BIT] && !pwm_on) [*8];
  endsequence

  gate_overlap_a: assert property (!(high_gate_drive && low_gate_drive))
    else $error("both gates high together");
  global_off_a: assert property (drv_off |=> !high_gate_drive && !low_gate_drive)
    else $error("gate high while driver off");
  high_off_a: assert property (st_q.test[TST_HIGH_OFF_BIT] |=> !high_gate_drive)
    else $error("high gate high while its side is off");
  low_keeps_a: assert property (low_run_s |=> low_gate_drive)
    else $error("low gate stopped although only high side is off");
  resume_a: assert property (high_run_s |=> high_gate_drive)
    else $error("high gate did not resume after driver enable");
  strength_a: assert property (bus.wr && bus.addr == REG_DRIVER_OPTION
      |=> high_drive_reduced == $past(bus.wdata[OPT_REDUCED_BIT]))
    else $error("strength select not taken from write");
  period_wrap_a: assert property (st_q.count >= st_q.period |=> st_q.count == '0)
    else $error("period timer did not wrap");
  period_range_a: assert property (st_q.period >= PER_LO && st_q.period <= PER_HI)
    else $error("period outside switching range");
endmodule // gdt_top

/* sim/gdt_fet_model.sv */
// model of the external power stage seen from the two gate pins
`timescale 1ns/1ps
module gdt_fet_model (
  input wire logic mclk,
  input wire logic high_gate_drive,
  input wire logic low_gate_drive,
  output logic [15:0] overlap_cnt,
  output logic node_driven
);
  logic [15:0] hits = 16'h0000;
  // switch node floats when neither transistor conducts
  assign node_driven = high_gate_drive | low_gate_drive;
  assign overlap_cnt = hits;
  // both on shorts the input rail; counted so the bench can see it
  always @(posedge mclk) begin
    if (high_gate_drive === 1'b1 && low_gate_drive === 1'b1) hits <= hits + 16'h0001;
  end
endmodule // gdt_fet_model

/* sim/test_gate_drive_dead_time_control.sv */
// self-checking bench of the gate-drive dead-time block
`timescale 1ns/1ps
module test_gate_drive_dead_time_control import gdt_pkg::*;;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  gdt_req_t bus = '0;
  logic [REG_DW-1:0] reg_rdata;
  logic high_gate_drive;
  logic low_gate_drive;
  logic high_drive_reduced;
  logic [15:0] overlap_cnt;
  logic node_driven;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  bit sh;
  bit sl;
  int hc[3] = '{15, 7, 1};
  int lc[3] = '{0, 3, 15};

  always #5 mclk = ~mclk;

  gdt_top i_gdt_top (.mclk(mclk), .rst(rst), .bus(bus), .reg_rdata(reg_rdata),
    .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
    .high_drive_reduced(high_drive_reduced));
  gdt_fet_model i_gdt_fet_model (.mclk(mclk), .high_gate_drive(high_gate_drive),
    .low_gate_drive(low_gate_drive), .overlap_cnt(overlap_cnt), .node_driven(node_driven));

  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [REG_AW-1:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask

  task rd_chk(input logic [REG_AW-1:0] a, input logic [15:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1 chk(reg_rdata, exp);
  endtask

  task watch(input int cycles, output bit h, output bit l);
    h = 1'b0;
    l = 1'b0;
    repeat (cycles) begin
      @(posedge mclk);
      #1;
      h |= (high_gate_drive === 1'b1);
      l |= (low_gate_drive === 1'b1);
    end
  endtask

  // cycles from the other gate falling to this gate rising
  task gap(input bit hs, output int g);
    int k;
    k = 0;
    g = 0;
    while ((hs ? low_gate_drive : high_gate_drive) !== 1'b1 && k < 3000) begin
      @(posedge mclk);
      #1 k++;
    end
    while ((hs ? low_gate_drive : high_gate_drive) !== 1'b0 && k < 3000) begin
      @(posedge mclk);
      #1 k++;
    end
    while ((hs ? high_gate_drive : low_gate_drive) !== 1'b1 && k < 3000) begin
      @(posedge mclk);
      #1 k++;
      g++;
    end
  endtask

  function automatic int exp_gap(int code);
    return (code * DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  endfunction

  task t_reset();
    #1 chk({high_gate_drive, low_gate_drive, high_drive_reduced}, 16'h0000);
    rd_chk(REG_DRIVER_TEST_CONTROL, 16'h0001);
    rd_chk(REG_PERIOD, 16'h03e7);
    rd_chk(REG_DUTY, 16'h0000);
    rd_chk(REG_DEAD_TIME_CONFIG, 16'h0000);
    rd_chk(REG_DRIVER_OPTION, 16'h0000);
    rd_chk(REG_STATUS, 16'h0000);
    rd_chk(3'h7, 16'h0000);
    watch(150, sh, sl);
    chk({sh, sl}, 16'h0000);
    $display("test reset done");
  endtask

  task t_period();
    wr(REG_PERIOD, 16'h0005);
    rd_chk(REG_PERIOD, 16'h003e);
    wr(REG_PERIOD, 16'h03ff);
    rd_chk(REG_PERIOD, 16'h03e7);
    wr(REG_PERIOD, 16'h003e);
    wr(REG_DUTY, 16'h001f);
    wr(REG_DRIVER_TEST_CONTROL, 16'h0000);
    gap(1'b1, n);
    n = 0;
    while (high_gate_drive !== 1'b0 && n < 3000) begin
      @(posedge mclk);
      #1 n++;
    end
    while (high_gate_drive !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      #1 n++;
    end
    chk(16'(n), 16'(PERIOD_MIN_CYC));
    // high rose two edges after the wrap; the read samples the timer one edge later still
    rd_chk(REG_COUNT, 16'h0003);
    $display("test period done");
  endtask

  task t_dead();
    for (int i = 0; i < 3; i++) begin
      wr(REG_DEAD_TIME_CONFIG, 16'((lc[i] << DT_LOW_LSB) | (hc[i] << DT_HIGH_LSB)));
      rd_chk(REG_DEAD_TIME_CONFIG, 16'((lc[i] << DT_LOW_LSB) | (hc[i] << DT_HIGH_LSB)));
      repeat (70) @(posedge mclk);
      gap(1'b1, n);
      chk(16'(n), 16'(exp_gap(hc[i])));
      gap(1'b0, n);
      chk(16'(n), 16'(exp_gap(lc[i])));
    end
    $display("test dead time done");
  endtask

  task t_option();
    wr(REG_DEAD_TIME_CONFIG, 16'h00ff);
    wr(REG_DRIVER_OPTION, 16'h0003);
    repeat (70) @(posedge mclk);
    gap(1'b1, n);
    chk(16'(n), 16'h0001);
    // high just rose early in the period: high gate, pwm request, low gate clear
    rd_chk(REG_STATUS, 16'h0005);
    gap(1'b0, n);
    chk(16'(n), 16'h0001);
    wr(REG_DRIVER_OPTION, 16'h0004);
    repeat (3) @(posedge mclk);
    #1 chk(high_drive_reduced, 16'h0001);
    wr(REG_DRIVER_OPTION, 16'h0000);
    repeat (3) @(posedge mclk);
    #1 chk(high_drive_reduced, 16'h0000);
    $display("test option done");
  endtask

  task t_off();
    logic [15:0] ctl[4] = '{16'h0001, 16'h0000, 16'h0002, 16'h0004};
    logic [15:0] seen[4] = '{16'h0000, 16'h0003, 16'h0001, 16'h0002};
    for (int i = 0; i < 4; i++) begin
      wr(REG_DRIVER_TEST_CONTROL, ctl[i]);
      repeat (3) @(posedge mclk);
      watch(150, sh, sl);
      chk({sh, sl}, seen[i]);
      if (i == 0) chk(node_driven, 16'h0000);
    end
    chk(overlap_cnt, 16'h0000);
    $display("test driver off done");
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // generous ceiling: the scenarios need under two thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_period();
    t_dead();
    t_option();
    t_off();
    give_verdict();
  end
endmodule // test_gate_drive_dead_time_control
